// file: bench/sar_cmd_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sar_cmd_asserts
  import sar_pkg::*;
(
  input wire logic clk_i, reset_i, cmd_valid_i, cmd_ready_o, cmd_read_i, rsp_valid_o,
  input wire logic rsp_ready_i, rsp_last_o, rsp_read_o,
  input wire logic [7:0] command_identifier_i, cmd_len_i, rsp_data_o,
  input wire logic [1:0] shift_o,
  input wire logic [3:0] gain_o,
  input wire logic [10:0] start_o,
  input wire logic [11:0] first_pixel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire rd_a5 = cmd_valid_i && cmd_ready_o && cmd_read_i && command_identifier_i == 8'hA5 && cmd_len_i == 8'h01;
  wire rd_a9 = cmd_valid_i && cmd_ready_o && cmd_read_i && command_identifier_i == 8'hA9 && cmd_len_i == 8'h02;
  a_gain_decode: assert property (gain_o == 4'h1 << shift_o) else $error("gain");
  a_first_pixel: assert property (first_pixel_o == start_o + 12'h001) else $error("first");
  a_rsp_flag: assert property (rsp_valid_o |-> !rsp_read_o) else $error("flag");
  a_write_silent: assert property (cmd_valid_i && cmd_ready_o && !cmd_read_i |=> !rsp_valid_o)
    else $error("write rsp");
  a_shift_one: assert property (rd_a5 |=> rsp_valid_o && rsp_last_o) else $error("a5 rd");
  a_start_two: assert property (rd_a9 |=> rsp_valid_o && !rsp_last_o) else $error("a9 rd");
  a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o))
    else $error("hold");
  a_busy_rsp: assert property (rsp_valid_o |-> !cmd_ready_o) else $error("busy");
  c_rd_a5: cover property (rd_a5);
  c_rd_a9: cover property (rd_a9);
  c_stall: cover property (rsp_valid_o && !rsp_ready_i);
endmodule
bind sar_cmd sar_cmd_asserts u_chk (.*);
`default_nettype wire

// file: bench/sar_host.sv
`timescale 1ns/100ps
`default_nettype none
module sar_host (
  input wire logic clk_i, rdy_i,
  output logic v_o, r_o, dv_o, rr_o,
  output logic [7:0] id_o, len_o, d_o
);
  initial {v_o, r_o, dv_o, rr_o, id_o, len_o, d_o} = '0;
  // Random stalls on the response side
  always @(posedge clk_i) rr_o <= #1 ($urandom % 3 != 0);
  task send(input logic [7:0] id, input logic rd, input logic [7:0] n, input logic [15:0] v);
    int k;
    for (k = 0; k < 50 && !rdy_i; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 50) begin
      testbench.err_total++;
      testbench.report_and_stop();
    end
    {v_o, id_o, r_o, len_o} = {1'b1, id, rd, n};
    @(posedge clk_i) #1 v_o = 0;
    for (k = 0; k < n && !rd; k++) begin
      {dv_o, d_o} = {1'b1, v[8*k+:8]};
      @(posedge clk_i) #1;
    end
    {dv_o, d_o} = {1'b0, ~d_o};
    @(posedge clk_i) #1;
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module testbench;
  logic clk_i = 0, reset_i = 1, s2k = 1, cv, rd, dv, rr, rv, last, rdy, rrd;
  logic [7:0] id, len, d, rdat, rcmd, rlen;
  logic [1:0] sh;
  logic [3:0] gn;
  logic [10:0] st, v;
  logic [11:0] fp;
  logic [24:0] q[$], e;
  int err_total = 0, checked = 0;
  initial forever #10 clk_i = ~clk_i;
  sar_cmd DUT (.clk_i(clk_i), .reset_i(reset_i), .sensor_2k_i(s2k), .cmd_valid_i(cv),
    .command_identifier_i(id), .cmd_read_i(rd), .cmd_len_i(len), .data_valid_i(dv), .data_i(d),
    .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_cmd_o(rcmd), .rsp_read_o(rrd), .rsp_len_o(rlen),
    .rsp_data_o(rdat), .rsp_last_o(last), .rsp_ready_i(rr), .shift_o(sh), .gain_o(gn),
    .start_o(st), .first_pixel_o(fp));
  sar_host h (.clk_i(clk_i), .rdy_i(rdy), .v_o(cv), .r_o(rd), .dv_o(dv), .rr_o(rr),
    .id_o(id), .len_o(len), .d_o(d));
  always @(posedge clk_i) if (!reset_i && rv === 1 && rr === 1) begin
    e = q.size() ? q.pop_front() : 'x;
    `CHK({rcmd, rlen, rdat, last}, e)
    `CHK(rrd, 1'b0)
  end
  task report_and_stop;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hC66F857A));
    repeat (6) @(posedge clk_i);
    #1 reset_i = 0;
    for (int c = 0; c < 4; c++) begin
      h.send(8'hA5, 0, 8'h01, 16'(c));
      `CHK(gn, 4'h1 << c)
      q.push_back({8'hA5, 8'h01, 8'(c), 1'b1});
      h.send(8'hA5, 1, 8'h01, 16'h0);
    end
    $display("shift test done");
    v = 11'($urandom);
    h.send(8'hA9, 0, 8'h02, 16'(v));
    `CHK(fp, {1'b0, v} + 12'h001)
    q.push_back({8'hA9, 8'h02, v[7:0], 1'b0});
    q.push_back({8'hA9, 8'h02, 5'h00, v[10:8], 1'b1});
    h.send(8'hA9, 1, 8'h02, 16'h0);
    s2k = 0;
    h.send(8'hA9, 0, 8'h02, 16'h0400);
    `CHK(st, v)
    h.send(8'hA9, 0, 8'h02, 16'h03FF);
    `CHK(st, 11'h3FF)
    for (int k = 0; k < 50 && q.size(); k++) @(posedge clk_i);
    if (q.size()) err_total++;
    $display("start test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verilog/sar_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module sar_cmd
  import sar_pkg::*;
(
  // Clock, reset and sensor size select
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   sensor_2k_i,
  // Framed command in
  input  wire logic                   cmd_valid_i,
  input  wire logic [7:0]             command_identifier_i,
  input  wire logic                   cmd_read_i,
  input  wire logic [7:0]             cmd_len_i,
  input  wire logic                   data_valid_i,
  input  wire logic [7:0]             data_i,
  output logic                        cmd_ready_o,
  // Response out
  output logic                        rsp_valid_o,
  output logic [7:0]                  rsp_cmd_o,
  output logic                        rsp_read_o,
  output logic [7:0]                  rsp_len_o,
  output logic [7:0]                  rsp_data_o,
  output logic                        rsp_last_o,
  input  wire logic                   rsp_ready_i,
  // Settings to datapath
  output logic [SAR_SHIFT_W-1:0]      shift_o,
  output logic [3:0]                  gain_o,
  output logic [SAR_START_W-1:0]      start_o,
  output logic [SAR_START_W:0]        first_pixel_o
);
  sar_regs_t r_r;
  sar_regs_t r_nxt;
  logic [15:0] wval;
  logic [SAR_START_W-1:0] lim;

  assign lim = sensor_2k_i ? SAR_START_MAX_2K : SAR_START_MAX_1K;

  always_comb begin
    r_nxt = r_r;
    wval  = {data_i, r_r.low_byte};
    case (r_r.state)
      SAR_IDLE: begin
        if (cmd_valid_i && command_identifier_i == SAR_CMD_SHIFT && cmd_len_i == SAR_LEN_SHIFT) begin
          r_nxt.is_start = 1'b0;
          if (cmd_read_i) begin
            r_nxt.state     = SAR_RESP1;
            r_nxt.rsp_valid = 1'b1;
            r_nxt.rsp_last  = 1'b1;
            r_nxt.rsp_cmd   = SAR_CMD_SHIFT;
            r_nxt.rsp_len   = SAR_LEN_SHIFT;
            r_nxt.rsp_data  = {6'h00, r_r.shift};
          end else begin
            r_nxt.state = SAR_WDATA1;
          end
        end else if (cmd_valid_i && command_identifier_i == SAR_CMD_START
                     && cmd_len_i == SAR_LEN_START) begin
          r_nxt.is_start = 1'b1;
          if (cmd_read_i) begin
            r_nxt.state     = SAR_RESP0;
            r_nxt.rsp_valid = 1'b1;
            r_nxt.rsp_last  = 1'b0;
            r_nxt.rsp_cmd   = SAR_CMD_START;
            r_nxt.rsp_len   = SAR_LEN_START;
            r_nxt.rsp_data  = r_r.start[7:0];
          end else begin
            r_nxt.state = SAR_WDATA0;
          end
        end
      end
      SAR_WDATA0: begin
        if (data_valid_i) begin
          r_nxt.low_byte = data_i;
          r_nxt.state    = SAR_WDATA1;
        end
      end
      SAR_WDATA1: begin
        if (data_valid_i) begin
          r_nxt.state = SAR_IDLE;
          if (r_r.is_start) begin
            if (wval[SAR_START_W-1:0] <= lim && wval[15:SAR_START_W] == 5'h00)
              r_nxt.start = wval[SAR_START_W-1:0];
          end else begin
            r_nxt.shift = data_i[SAR_SHIFT_W-1:0];
          end
        end
      end
      SAR_RESP0: begin
        if (rsp_ready_i) begin
          r_nxt.state    = SAR_RESP1;
          r_nxt.rsp_last = 1'b1;
          r_nxt.rsp_data = {5'h00, r_r.start[SAR_START_W-1:8]};
        end
      end
      SAR_RESP1: begin
        if (rsp_ready_i) begin
          r_nxt.state     = SAR_IDLE;
          r_nxt.rsp_valid = 1'b0;
          r_nxt.rsp_last  = 1'b0;
        end
      end
      default: r_nxt.state = SAR_IDLE;
    endcase
    if (reset_i) begin
      r_nxt           = '0;
      r_nxt.state     = SAR_IDLE;
      r_nxt.shift     = SAR_SHIFT_RST;
      r_nxt.start     = SAR_START_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    r_r <= r_nxt;
  end

  assign cmd_ready_o   = (r_r.state == SAR_IDLE);
  assign rsp_valid_o   = r_r.rsp_valid;
  assign rsp_cmd_o     = r_r.rsp_cmd;
  assign rsp_read_o    = 1'b0;
  assign rsp_len_o     = r_r.rsp_len;
  assign rsp_data_o    = r_r.rsp_data;
  assign rsp_last_o    = r_r.rsp_last;
  assign shift_o       = r_r.shift;
  assign gain_o        = 4'h1 << r_r.shift;
  assign start_o       = r_r.start;
  assign first_pixel_o = {1'b0, r_r.start} + SAR_FIRST_OFFSET;
endmodule
`default_nettype wire

// file: verilog/sar_pkg.sv
package sar_pkg;
  localparam logic [7:0]  SAR_CMD_SHIFT     = 8'hA5;
  localparam logic [7:0]  SAR_CMD_START     = 8'hA9;
  localparam logic [7:0]  SAR_LEN_SHIFT     = 8'h01;
  localparam logic [7:0]  SAR_LEN_START     = 8'h02;
  localparam logic [1:0]  SAR_SHIFT_RST     = 2'h0;
  localparam logic [10:0] SAR_START_RST     = 11'h000;
  localparam logic [10:0] SAR_START_MAX_1K  = 11'h3FF;
  localparam logic [10:0] SAR_START_MAX_2K  = 11'h7FF;
  localparam logic [11:0] SAR_FIRST_OFFSET  = 12'h001;
  localparam int          SAR_SHIFT_W       = 2;
  localparam int          SAR_START_W       = 11;

  typedef enum logic [2:0] {
    SAR_IDLE,
    SAR_WDATA0,
    SAR_WDATA1,
    SAR_RESP0,
    SAR_RESP1
  } sar_state_t;

  typedef struct packed {
    sar_state_t             state;
    logic                   is_start;
    logic [7:0]             low_byte;
    logic [SAR_SHIFT_W-1:0] shift;
    logic [SAR_START_W-1:0] start;
    logic                   rsp_valid;
    logic                   rsp_last;
    logic [7:0]             rsp_data;
    logic [7:0]             rsp_cmd;
    logic [7:0]             rsp_len;
  } sar_regs_t;
endpackage
